// ---- ucsi_pkg.sv ----
package ucsi_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] INPUT_CFG_ADDR = 8'h23;
   localparam logic [7:0] LANE_OVR_ADDR = 8'h34;
   localparam logic [7:0] OUTPUT_CFG_ADDR = 8'h6A;
   localparam logic [7:0] STATUS_ADDR = 8'h40;
   // field positions
   localparam int IN_CODE_LO = 3;
   localparam int IN_CODE_TOP = 5;
   localparam int OUT_CODE_LO = 4;
   localparam int OVR_LO = 3;
   // ----------------------------------------
   // values after reset
   // ----------------------------------------
   localparam logic [2:0] IN_CODE_RST = 3'h0;
   localparam logic [2:0] OUT_CODE_RST = 3'h0;
   localparam logic [1:0] OVR_RST = 2'h0;
   // lane override encodings
   localparam logic [1:0] OVR_FORCE_ONE = 2'h1;
   localparam logic [1:0] OVR_FORCE_TWO = 2'h2;
   // output configuration codes
   localparam logic [2:0] OUT_4L_ONE = 3'h0;
   localparam logic [2:0] OUT_4L_BOTH = 3'h1;
   localparam logic [2:0] OUT_2L_ONE = 3'h2;
   localparam logic [2:0] OUT_2L_BOTH = 3'h3;
   // ----------------------------------------
   // rates and counts
   // ----------------------------------------
   localparam logic [3:0] MULT_FOUR_LANE = 4'h7;
   localparam logic [3:0] MULT_TWO_LANE = 4'hE;
   localparam logic [7:0] PCLK_MIN_LOW = 8'h19;
   localparam logic [7:0] PCLK_MIN_DUAL4 = 8'h32;
   localparam logic [7:0] PCLK_MAX_SINGLE = 8'h60;
   localparam logic [7:0] PCLK_MAX_DUAL4 = 8'hAA;
   localparam logic [7:0] PCLK_MAX_DUAL2 = 8'h30;
   localparam logic [5:0] SYMBOL_LAST = 6'h22;
   localparam int CLK_PERIOD_NS = 10;
   localparam int STRAP_SETTLE_NS = 30;
   localparam logic [1:0] STRAP_SETTLE_CYC =
      2'((STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_SETTLE = 2'h1,
      ST_RUN = 2'h2
   } ucsi_load_state_type;
endpackage : ucsi_pkg

// ---- ucsi_link_mon.sv ----
`timescale 1ns/10ps
module ucsi_link_mon (
   // clock and reset
   input wire logic link_clk,
   input wire logic rst_n,
   // recovered serial bits
   input wire logic [1:0] lane_bit_valid,
   input wire logic video_blank,
   // status, link domain
   output logic second_lane_seen,
   output logic blank_level
);
   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic [5:0] pos0;
      logic [5:0] pos1;
      logic [5:0] idle1;
      logic seen;
      logic blank;
   } ucsi_link_state_type;

   ucsi_link_state_type r_reg;
   ucsi_link_state_type r_next;

   // ----------------------------------------
   // symbol framing and lane detection
   // ----------------------------------------
   always_comb begin
      r_next = r_reg;
      r_next.rst_s1 = 1'b1;
      r_next.rst_s2 = r_reg.rst_s1;
      r_next.blank = video_blank;
      if (r_reg.rst_s2) begin
         if (lane_bit_valid[0]) begin
            // 35-bit symbol boundary on each pair
            r_next.pos0 = (r_reg.pos0 == ucsi_pkg::SYMBOL_LAST) ? 6'h00 : r_reg.pos0 + 6'h01;
         end
         if (lane_bit_valid[1]) begin
            r_next.pos1 = (r_reg.pos1 == ucsi_pkg::SYMBOL_LAST) ? 6'h00 : r_reg.pos1 + 6'h01;
            r_next.idle1 = 6'h00;
            if (r_reg.pos1 == ucsi_pkg::SYMBOL_LAST) begin
               r_next.seen = 1'b1;
            end
         end else if (lane_bit_valid[0]) begin
            // a whole symbol on lane 0 with lane 1 silent drops it
            if (r_reg.idle1 == ucsi_pkg::SYMBOL_LAST) begin
               r_next.seen = 1'b0;
            end else begin
               r_next.idle1 = r_reg.idle1 + 6'h01;
            end
         end
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign second_lane_seen = r_reg.seen;
   assign blank_level = r_reg.blank;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_symbol_wrap;
      @(posedge link_clk) disable iff (!rst_n)
      (lane_bit_valid[0] && r_reg.rst_s2 && r_reg.pos0 == ucsi_pkg::SYMBOL_LAST)
         |=> r_reg.pos0 == 6'h00;
   endproperty
   a_symbol_wrap: assert property (p_symbol_wrap) else $error("symbol not 35 bits");

   property p_symbol_bound;
      @(posedge link_clk) disable iff (!rst_n)
      r_reg.pos0 <= ucsi_pkg::SYMBOL_LAST && r_reg.pos1 <= ucsi_pkg::SYMBOL_LAST;
   endproperty
   a_symbol_bound: assert property (p_symbol_bound) else $error("symbol count overrun");
endmodule : ucsi_link_mon

// ---- ucsi_mode_select.sv ----
`timescale 1ns/10ps
// Behaviour
// - configuration comes from strap inputs or register fields 0x23[5:3], 0x6A[5:4]
// - each strap input resolves to one of eight codes, 0 to 7
// - one or two serial lanes detected automatically; 0x34[4:3] overrides
// - each serial pair carries repeated 35-bit symbols with embedded clock
// - two output ports, each one clock lane plus two or four data lanes
// - unused output lanes are held in LP11
// - clock and data lanes leave high speed during blanking
// - one input lane, four output lanes: pclk 25-96 MHz, lane rate 7x
// - one input lane, two output lanes: lane rate 14x pclk
// - two input lanes, four output lanes: pclk 50-170 MHz, merged, 7x
// - two input lanes, two output lanes: pclk 25-48 MHz, merged, 14x
// - replicate mode copies active lanes onto the second port
// - output codes: 0 4L one, 1 4L both, 2 2L one, 3 2L both
// - single-port codes drive the port named by the input port select
// - dual-port codes enable both ports, ignoring port select
// - input codes: port by bit 2, 5/20 Mbps back channel, even twisted pair
module ucsi_mode_select (
   // clocks and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic link_clk,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // strap codes
   input wire logic [2:0] output_config_select,
   input wire logic [2:0] input_config_select,
   // link side
   input wire logic [1:0] lane_bit_valid,
   input wire logic video_blank,
   // first port lane control
   output logic [3:0] first_port_data_lanes_hs,
   output logic [3:0] first_port_data_lanes_lp11,
   output logic first_port_clock_lane_hs,
   output logic first_port_clock_lane_lp11,
   // second port lane control
   output logic [3:0] second_port_lane_bus_hs,
   output logic [3:0] second_port_lane_bus_lp11,
   output logic second_port_clock_lane_hs,
   output logic second_port_clock_lane_lp11,
   output logic second_port_replicate,
   // resolved configuration
   output logic two_serial_lanes,
   output logic [3:0] lane_rate_mult,
   output logic [7:0] pclk_min_mhz,
   output logic [7:0] pclk_max_mhz,
   output logic back_channel_20m,
   output logic twisted_pair_cable,
   output logic config_reserved,
   output logic config_ready
);
   // ----------------------------------------
   // decode functions
   // ----------------------------------------
   function automatic logic out_is_reserved(input logic [2:0] code);
      return code[2];
   endfunction : out_is_reserved

   function automatic logic out_is_dual(input logic [2:0] code);
      return !code[2] && code[0];
   endfunction : out_is_dual

   function automatic logic out_is_four(input logic [2:0] code);
      return !code[2] && !code[1];
   endfunction : out_is_four

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      ucsi_pkg::ucsi_load_state_type st;
      logic [1:0] settle;
      logic [2:0] sin1;
      logic [2:0] sin2;
      logic [2:0] sout1;
      logic [2:0] sout2;
      logic lanes_s1;
      logic lanes_s2;
      logic blank_s1;
      logic blank_s2;
      logic [2:0] in_code;
      logic [2:0] out_code;
      logic in_written;
      logic out_written;
      logic [1:0] ovr;
      logic [7:0] rdata;
      logic [3:0] p0_en;
      logic [3:0] p1_en;
      logic p0_clk;
      logic p1_clk;
      logic two_lanes;
      logic [3:0] mult;
      logic [7:0] pmin;
      logic [7:0] pmax;
      logic bc20;
      logic tp;
      logic rsvd;
      logic repl;
      logic ready;
   } ucsi_state_type;

   ucsi_state_type r_reg;
   ucsi_state_type r_next;
   logic lane_seen_link;
   logic blank_link;

   ucsi_link_mon u_link_mon (
      .link_clk(link_clk),
      .rst_n(rst_n),
      .lane_bit_valid(lane_bit_valid),
      .video_blank(video_blank),
      .second_lane_seen(lane_seen_link),
      .blank_level(blank_link)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic two;
      logic four;
      logic [3:0] lanes;
      two = 1'b0;
      four = 1'b0;
      lanes = 4'h0;
      r_next = r_reg;
      // straps and link levels: two flops before use
      r_next.sin1 = input_config_select;
      r_next.sin2 = r_reg.sin1;
      r_next.sout1 = output_config_select;
      r_next.sout2 = r_reg.sout1;
      r_next.lanes_s1 = lane_seen_link;
      r_next.lanes_s2 = r_reg.lanes_s1;
      r_next.blank_s1 = blank_link;
      r_next.blank_s2 = r_reg.blank_s1;

      // strap latch after reset
      unique case (r_reg.st)
         ucsi_pkg::ST_SETTLE: begin
            if (r_reg.settle == ucsi_pkg::STRAP_SETTLE_CYC) begin
               if (!r_reg.in_written) begin
                  r_next.in_code = r_reg.sin2;
               end
               if (!r_reg.out_written) begin
                  r_next.out_code = r_reg.sout2;
               end
               r_next.st = ucsi_pkg::ST_RUN;
            end else begin
               r_next.settle = r_reg.settle + 2'h1;
            end
         end
         ucsi_pkg::ST_RUN: begin
            r_next.ready = 1'b1;
         end
      endcase

      // register writes win over the strap value
      if (reg_wr) begin
         unique case (reg_addr)
            ucsi_pkg::INPUT_CFG_ADDR: begin
               r_next.in_code = {reg_wdata[ucsi_pkg::IN_CODE_TOP],
                                 reg_wdata[ucsi_pkg::IN_CODE_LO +: 2]};
               r_next.in_written = 1'b1;
            end
            ucsi_pkg::OUTPUT_CFG_ADDR: begin
               r_next.out_code = {1'b0, reg_wdata[ucsi_pkg::OUT_CODE_LO +: 2]};
               r_next.out_written = 1'b1;
            end
            ucsi_pkg::LANE_OVR_ADDR: begin
               r_next.ovr = reg_wdata[ucsi_pkg::OVR_LO +: 2];
            end
            default: begin
            end
         endcase
      end

      // read data stands only in the cycle after the strobe
      r_next.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            ucsi_pkg::INPUT_CFG_ADDR: begin
               r_next.rdata = {2'h0, r_reg.in_code[2], r_reg.in_code[1:0], 3'h0};
            end
            ucsi_pkg::OUTPUT_CFG_ADDR: begin
               r_next.rdata = {2'h0, r_reg.out_code[1:0], 4'h0};
            end
            ucsi_pkg::LANE_OVR_ADDR: begin
               r_next.rdata = {3'h0, r_reg.ovr, 3'h0};
            end
            ucsi_pkg::STATUS_ADDR: begin
               r_next.rdata = {r_reg.ready, r_reg.two_lanes, r_reg.in_code, r_reg.out_code};
            end
            default: begin
               r_next.rdata = 8'h00;
            end
         endcase
      end

      // serial lane count, override before detection
      if (r_reg.ovr == ucsi_pkg::OVR_FORCE_ONE) begin
         two = 1'b0;
      end else if (r_reg.ovr == ucsi_pkg::OVR_FORCE_TWO) begin
         two = 1'b1;
      end else begin
         two = r_reg.lanes_s2;
      end
      r_next.two_lanes = two;

      // output lanes per port
      four = out_is_four(r_reg.out_code);
      lanes = four ? 4'hF : 4'h3;
      r_next.rsvd = out_is_reserved(r_reg.out_code);
      r_next.repl = out_is_dual(r_reg.out_code);
      if (out_is_reserved(r_reg.out_code)) begin
         // undefined codes: everything parked in LP11 as the safe choice
         r_next.p0_en = 4'h0;
         r_next.p1_en = 4'h0;
      end else if (out_is_dual(r_reg.out_code)) begin
         r_next.p0_en = lanes;
         r_next.p1_en = lanes;
      end else begin
         r_next.p0_en = r_reg.in_code[2] ? 4'h0 : lanes;
         r_next.p1_en = r_reg.in_code[2] ? lanes : 4'h0;
      end
      r_next.p0_clk = !out_is_reserved(r_reg.out_code) &&
                      (out_is_dual(r_reg.out_code) || !r_reg.in_code[2]);
      r_next.p1_clk = !out_is_reserved(r_reg.out_code) &&
                      (out_is_dual(r_reg.out_code) || r_reg.in_code[2]);

      // per-lane rate and accepted pixel clock range
      r_next.mult = four ? ucsi_pkg::MULT_FOUR_LANE : ucsi_pkg::MULT_TWO_LANE;
      if (!two) begin
         r_next.pmin = ucsi_pkg::PCLK_MIN_LOW;
         r_next.pmax = ucsi_pkg::PCLK_MAX_SINGLE;
      end else if (four) begin
         r_next.pmin = ucsi_pkg::PCLK_MIN_DUAL4;
         r_next.pmax = ucsi_pkg::PCLK_MAX_DUAL4;
      end else begin
         r_next.pmin = ucsi_pkg::PCLK_MIN_LOW;
         r_next.pmax = ucsi_pkg::PCLK_MAX_DUAL2;
      end

      // input code fields
      r_next.bc20 = r_reg.in_code[1];
      r_next.tp = !r_reg.in_code[0];
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= '0;
         r_reg.st <= ucsi_pkg::ST_SETTLE;
         r_reg.in_code <= ucsi_pkg::IN_CODE_RST;
         r_reg.out_code <= ucsi_pkg::OUT_CODE_RST;
         r_reg.ovr <= ucsi_pkg::OVR_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // blanking drops every lane to low power
   assign first_port_data_lanes_hs = r_reg.p0_en & {4{!r_reg.blank_s2}};
   assign first_port_data_lanes_lp11 = ~first_port_data_lanes_hs;
   assign first_port_clock_lane_hs = r_reg.p0_clk && !r_reg.blank_s2;
   assign first_port_clock_lane_lp11 = !first_port_clock_lane_hs;
   assign second_port_lane_bus_hs = r_reg.p1_en & {4{!r_reg.blank_s2}};
   assign second_port_lane_bus_lp11 = ~second_port_lane_bus_hs;
   assign second_port_clock_lane_hs = r_reg.p1_clk && !r_reg.blank_s2;
   assign second_port_clock_lane_lp11 = !second_port_clock_lane_hs;
   assign second_port_replicate = r_reg.repl;
   assign two_serial_lanes = r_reg.two_lanes;
   assign lane_rate_mult = r_reg.mult;
   assign pclk_min_mhz = r_reg.pmin;
   assign pclk_max_mhz = r_reg.pmax;
   assign back_channel_20m = r_reg.bc20;
   assign twisted_pair_cable = r_reg.tp;
   assign config_reserved = r_reg.rsvd;
   assign config_ready = r_reg.ready;
   assign reg_rdata = r_reg.rdata;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   property p_reg_override;
      (reg_wr && reg_addr == ucsi_pkg::OUTPUT_CFG_ADDR)
         |=> r_reg.out_code == {1'b0, $past(reg_wdata[5:4])};
   endproperty
   a_reg_override: assert property (p_reg_override) else $error("out code write lost");

   property p_strap_latch;
      (r_reg.st == ucsi_pkg::ST_SETTLE && r_reg.settle == ucsi_pkg::STRAP_SETTLE_CYC
       && !r_reg.in_written && !reg_wr) |=> r_reg.in_code == $past(r_reg.sin2);
   endproperty
   a_strap_latch: assert property (p_strap_latch) else $error("strap not latched");

   property p_lane_override;
      (r_reg.ovr == ucsi_pkg::OVR_FORCE_TWO) ##1 (r_reg.ovr == ucsi_pkg::OVR_FORCE_TWO)
         |-> two_serial_lanes;
   endproperty
   a_lane_override: assert property (p_lane_override) else $error("override ignored");

   property p_four_lane;
      (r_reg.out_code == ucsi_pkg::OUT_4L_BOTH) |=> r_reg.p0_en == 4'hF && r_reg.p1_en == 4'hF;
   endproperty
   a_four_lane: assert property (p_four_lane) else $error("dual 4-lane wrong");

   property p_single_port;
      (r_reg.out_code == ucsi_pkg::OUT_2L_ONE && r_reg.in_code[2])
         |=> r_reg.p0_en == 4'h0 && r_reg.p1_en == 4'h3;
   endproperty
   a_single_port: assert property (p_single_port) else $error("port select wrong");

   property p_unused_lp11;
      (r_reg.p0_en == 4'h3) |-> first_port_data_lanes_lp11[3:2] == 2'h3;
   endproperty
   a_unused_lp11: assert property (p_unused_lp11) else $error("unused lane not LP11");

   property p_blank_lp;
      r_reg.blank_s2 |-> first_port_clock_lane_lp11 && second_port_lane_bus_hs == 4'h0;
   endproperty
   a_blank_lp: assert property (p_blank_lp) else $error("HS during blanking");

   property p_rate;
      out_is_four(r_reg.out_code) ##1 (out_is_four(r_reg.out_code) && $past(rst_n))
         |-> lane_rate_mult == ucsi_pkg::MULT_FOUR_LANE;
   endproperty
   a_rate: assert property (p_rate) else $error("four-lane rate not 7x");

   property p_dual_range;
      (two_serial_lanes && r_reg.out_code == ucsi_pkg::OUT_2L_ONE)
         |=> r_reg.two_lanes ? pclk_max_mhz == ucsi_pkg::PCLK_MAX_DUAL2 : 1'b1;
   endproperty
   a_dual_range: assert property (p_dual_range) else $error("dual 2-lane range");

   property p_input_fields;
      // the first edge out of reset still shows the reset values
      $past(rst_n) && $stable(r_reg.in_code) |-> back_channel_20m == r_reg.in_code[1]
         && twisted_pair_cable == !r_reg.in_code[0];
   endproperty
   a_input_fields: assert property (p_input_fields) else $error("input decode wrong");

   property p_read_once;
      !reg_rd |=> reg_rdata == 8'h00;
   endproperty
   a_read_once: assert property (p_read_once) else $error("read data held");

   c_replicate: cover property (second_port_replicate && second_port_lane_bus_hs == 4'hF);
   c_two_lanes: cover property (two_serial_lanes && lane_rate_mult == ucsi_pkg::MULT_TWO_LANE);
   c_override: cover property (reg_wr && reg_addr == ucsi_pkg::INPUT_CFG_ADDR && !config_ready);
   c_reserved: cover property (config_reserved);
endmodule : ucsi_mode_select

// ---- ucsi_ser_model.sv ----
`timescale 1ns/10ps
module ucsi_ser_model (
   // link clock and reset
   input wire logic link_clk,
   input wire logic rst_n,
   // bench controls
   input wire logic [1:0] lanes_on,
   input wire logic blank_req,
   // recovered stream
   output logic [1:0] lane_bit_valid,
   output logic video_blank
);
   logic [5:0] bit_cnt;
   logic [1:0] lanes_live;
   // ----------------------------------------
   // symbol framing
   // ----------------------------------------
   // lanes join or leave only at a symbol edge, so no symbol is ever cut short
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt <= 6'h00;
         lanes_live <= 2'h0;
         video_blank <= 1'b0;
      end else begin
         bit_cnt <= (bit_cnt == 6'h22) ? 6'h00 : bit_cnt + 6'h01;
         if (bit_cnt == 6'h22) begin
            lanes_live <= lanes_on;
         end
         video_blank <= blank_req;
      end
   end
   // one valid pulse per recovered bit on each live lane
   assign lane_bit_valid = lanes_live;
endmodule : ucsi_ser_model

// ---- tb_top.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
   logic ref_clk, link_clk, rst_n, reg_wr, reg_rd, video_blank, blank_req;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, pmin, pmax, d;
   logic [2:0] out_sel, in_sel;
   logic [1:0] lbv, lanes_on;
   logic [3:0] f_hs, f_lp, s_hs, s_lp, mult;
   logic fc_hs, fc_lp, sc_hs, sc_lp, repl, two, bc20, tp, resv, ready;
   int mismatches, tests_run;
   ucsi_mode_select i_ucsi_mode_select (.ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .output_config_select(out_sel), .input_config_select(in_sel),
      .lane_bit_valid(lbv), .video_blank(video_blank), .first_port_data_lanes_hs(f_hs),
      .first_port_data_lanes_lp11(f_lp), .first_port_clock_lane_hs(fc_hs),
      .first_port_clock_lane_lp11(fc_lp), .second_port_lane_bus_hs(s_hs),
      .second_port_lane_bus_lp11(s_lp), .second_port_clock_lane_hs(sc_hs),
      .second_port_clock_lane_lp11(sc_lp), .second_port_replicate(repl),
      .two_serial_lanes(two), .lane_rate_mult(mult), .pclk_min_mhz(pmin), .pclk_max_mhz(pmax),
      .back_channel_20m(bc20), .twisted_pair_cable(tp), .config_reserved(resv),
      .config_ready(ready));
   ucsi_ser_model i_ucsi_ser_model (.link_clk(link_clk), .rst_n(rst_n), .lanes_on(lanes_on),
      .blank_req(blank_req), .lane_bit_valid(lbv), .video_blank(video_blank));
   // ----------------------------------------
   // clocks and watchdog
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      link_clk = 1'b0;
      #13;
      forever #40 link_clk = ~link_clk;
   end
   initial begin
      #300us;
      mismatches++;
      tally_and_finish();
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd
   // expected data lanes of both ports from output and input code
   task automatic chk_lanes(input logic [3:0] f, input logic [3:0] s);
      `CHK("first lanes", f, f_hs)
      `CHK("first lp11", ~f, f_lp)
      `CHK("second lanes", s, s_hs)
      `CHK("second lp11", ~s, s_lp)
      `CHK("clock lanes", {f != 4'h0, s != 4'h0}, {fc_hs, sc_hs})
      `CHK("clock lp11", {f == 4'h0, s == 4'h0}, {fc_lp, sc_lp})
   endtask : chk_lanes
   task automatic wait_two(input logic v);
      for (int i = 0; i < 2000 && two !== v; i++) begin
         @(posedge ref_clk);
      end
      `CHK("two lanes", v, two)
   endtask : wait_two
   task automatic start(input logic [2:0] oc, input logic [2:0] ic);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      out_sel <= oc;
      in_sel <= ic;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 50 && ready !== 1'b1; i++) begin
         @(posedge ref_clk);
      end
      @(posedge ref_clk);
      `CHK("ready", 1'b1, ready)
   endtask : start
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      logic [3:0] m;
      mismatches = 0;
      tests_run = 0;
      {reg_addr, reg_wdata, reg_wr, reg_rd, blank_req} = '0;
      lanes_on = 2'h1;
      rst_n = 1'b0;
      out_sel = 3'h1;
      in_sel = 3'h5;
      start(3'h1, 3'h5);
      rd(8'h40, d);
      `CHK("status", 8'hA9, d)
      @(posedge ref_clk);
      #1;
      `CHK("rdata idle", 8'h00, reg_rdata)
      `CHK("strap cfg", 4'h8, {repl, two, bc20, tp})
      chk_lanes(4'hF, 4'hF);
      for (int ic = 0; ic < 8; ic++) begin
         wr(8'h23, 8'(ic << 3));
         `CHK("back channel", 1'(ic[1]), bc20)
         `CHK("twisted pair", 1'(!ic[0]), tp)
         rd(8'h40, d);
         `CHK("status in", 3'(ic), d[5:3])
         for (int oc = 0; oc < 4; oc++) begin
            wr(8'h6A, 8'(oc << 4));
            m = oc[1] ? 4'h3 : 4'hF;
            chk_lanes((oc[0] || !ic[2]) ? m : 4'h0, (oc[0] || ic[2]) ? m : 4'h0);
            `CHK("replicate", 1'(oc[0]), repl)
            `CHK("rate mult", oc[1] ? 4'hE : 4'h7, mult)
         end
      end
      blank_req <= 1'b1;
      repeat (40) @(posedge ref_clk);
      chk_lanes(4'h0, 4'h0);
      blank_req <= 1'b0;
      wr(8'h6A, 8'h00);
      `CHK("one lane range", 16'h1960, {pmin, pmax})
      lanes_on <= 2'h3;
      wait_two(1'b1);
      `CHK("dual4 range", 16'h32AA, {pmin, pmax})
      wr(8'h6A, 8'h20);
      `CHK("dual2 range", 16'h1930, {pmin, pmax})
      wr(8'h34, 8'h08);
      `CHK("force one", 1'b0, two)
      wr(8'h34, 8'h00);
      wait_two(1'b1);
      lanes_on <= 2'h1;
      wait_two(1'b0);
      wr(8'h34, 8'h10);
      `CHK("force two", 1'b1, two)
      rd(8'h55, d);
      `CHK("unmapped", 8'h00, d)
      // robustness only: a reserved strap code, parked safely by the design
      start(3'h6, 3'h2);
      `CHK("reserved", 3'h7, {resv, bc20, tp})
      chk_lanes(4'h0, 4'h0);
      wr(8'h6A, 8'h10);
      `CHK("write wins", 1'b0, resv)
      chk_lanes(4'hF, 4'hF);
      tally_and_finish();
   end
endmodule : tb_top
